// >>> hw/i2c_cond_map.svh
// constants for the i2c slave bus condition detector
`ifndef I2C_COND_MAP_SVH
`define I2C_COND_MAP_SVH
`define I2C_COND_HI_PREFIX 5'h1E
`define I2C_COND_LAST_DATA_BIT 4'h8
`define I2C_COND_ACK_BIT 4'h9
`define I2C_COND_CNT_RST 4'h0
`define I2C_COND_BYTE_RST 8'h00
`define I2C_COND_SYNC_RST 3'h7
`endif

// >>> hw/i2c_cond_pkg.sv
// types shared by the i2c slave bus condition detector
package i2c_cond_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_first,
    st_second,
    st_data,
    st_hold
  } slave_state_t;

  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
  } cond_evt_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;
endpackage : i2c_cond_pkg

// >>> hw/i2c_cond_detect.sv
// i2c slave bus condition detector with 10-bit read turnaround
`include "i2c_cond_map.svh"

module i2c_cond_detect
  import i2c_cond_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [9:0] own_addr,
  input wire logic ten_bit_mode,
  input wire logic tx_ready,
  output logic scl_o,
  output logic scl_oe,
  output cond_evt_t cond,
  output rx_byte_t rx_byte,
  output logic addressed,
  output logic read_mode,
  output logic prior_match
);

  // link domain: shift bits in on scl rising edges
  logic [7:0] shift_r;

  always_ff @(posedge scl_clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_r <= `I2C_COND_BYTE_RST;
    else
      shift_r <= {shift_r[6:0], sda_i};
  end

  // three stage pin synchronisers, level taken when stages two and three agree
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_p_r;
  logic sda_p_r;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_s_r <= `I2C_COND_SYNC_RST;
      sda_s_r <= `I2C_COND_SYNC_RST;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2])
        scl_q_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2])
        sda_q_r <= sda_s_r[2];
      scl_p_r <= scl_q_r;
      sda_p_r <= sda_q_r;
    end
  end

  logic sda_fall_hi;
  logic sda_rise_hi;
  logic scl_rise;
  logic scl_fall;
  logic busy_r;
  logic low_seen_r;
  logic is_start;
  logic is_restart;
  logic stop_ok;

  assign sda_fall_hi = sda_p_r & ~sda_q_r & scl_p_r & scl_q_r;
  assign sda_rise_hi = ~sda_p_r & sda_q_r & scl_p_r & scl_q_r;
  assign scl_rise = ~scl_p_r & scl_q_r;
  assign scl_fall = scl_p_r & ~scl_q_r;
  assign stop_ok = sda_rise_hi & busy_r & low_seen_r;
  assign is_restart = sda_fall_hi & busy_r & low_seen_r;
  assign is_start = sda_fall_hi & ~is_restart;

  // bus ownership and scl-low tracking
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_r <= 1'b0;
      low_seen_r <= 1'b0;
    end
    else if (sda_fall_hi)
    begin
      busy_r <= 1'b1;
      low_seen_r <= 1'b0;
    end
    else if (stop_ok)
    begin
      busy_r <= 1'b0;
      low_seen_r <= 1'b0;
    end
    else if (busy_r && !scl_q_r)
      low_seen_r <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cond <= '0;
    else
    begin
      cond.start <= is_start;
      cond.restart <= is_restart;
      cond.stop <= stop_ok;
    end
  end

  // bit counting and byte capture from the link domain; shift_r is stable while scl low
  logic [3:0] bit_cnt_r;
  logic capture;

  assign capture = scl_fall && bit_cnt_r == `I2C_COND_LAST_DATA_BIT;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      bit_cnt_r <= `I2C_COND_CNT_RST;
    else if (sda_fall_hi || stop_ok)
      bit_cnt_r <= `I2C_COND_CNT_RST;
    else if (scl_rise && busy_r)
      bit_cnt_r <= bit_cnt_r + 4'h1;
    else if (scl_fall && bit_cnt_r == `I2C_COND_ACK_BIT)
      bit_cnt_r <= `I2C_COND_CNT_RST;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_byte <= '0;
    else
    begin
      rx_byte.valid <= capture;
      if (capture)
        rx_byte.data <= shift_r;
    end
  end

  // address phase state machine
  slave_state_t state_r;
  logic hold_pend_r;
  logic hi_match;
  logic lo_match;
  logic ack_fall;

  assign hi_match = shift_r[7:1] == {`I2C_COND_HI_PREFIX, own_addr[9:8]};
  assign lo_match = shift_r == own_addr[7:0];
  assign ack_fall = scl_fall && bit_cnt_r == `I2C_COND_ACK_BIT;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= st_idle;
      addressed <= 1'b0;
      read_mode <= 1'b0;
      hold_pend_r <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (sda_fall_hi)
    begin
      state_r <= st_first;
      addressed <= 1'b0;
      read_mode <= 1'b0;
      hold_pend_r <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (stop_ok)
    begin
      state_r <= st_idle;
      addressed <= 1'b0;
      read_mode <= 1'b0;
      hold_pend_r <= 1'b0;
      scl_oe <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        st_idle:
          hold_pend_r <= 1'b0;
        st_first:
          if (capture)
          begin
            state_r <= st_data;
            if (!ten_bit_mode)
            begin
              addressed <= shift_r[7:1] == own_addr[6:0];
              read_mode <= shift_r[0];
            end
            else if (hi_match && !shift_r[0])
              state_r <= st_second;
            else if (hi_match && prior_match)
            begin
              addressed <= 1'b1;
              read_mode <= 1'b1;
              hold_pend_r <= 1'b1;
            end
          end
        st_second:
          if (capture)
          begin
            state_r <= st_data;
            addressed <= lo_match;
          end
        st_data:
          if (ack_fall && hold_pend_r)
          begin
            state_r <= st_hold;
            scl_oe <= 1'b1;
            hold_pend_r <= 1'b0;
          end
        st_hold:
          if (tx_ready)
          begin
            state_r <= st_data;
            scl_oe <= 1'b0;
          end
      endcase
    end
  end

  // prior match survives a restart, needed for the 10-bit read turnaround
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prior_match <= 1'b0;
    else if (stop_ok)
      prior_match <= 1'b0;
    else if (capture && state_r == st_second && lo_match)
      prior_match <= 1'b1;
    else if (capture && state_r == st_first && ten_bit_mode && (!hi_match || !shift_r[0]))
      prior_match <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      scl_o <= 1'b0;
    else
      scl_o <= 1'b0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_stop_detect;
    sda_rise_hi && busy_r && low_seen_r |=> cond.stop && !busy_r;
  endproperty
  a_stop_detect: assert property (p_stop_detect) else $error("stop not flagged");

  property p_stop_needs_low;
    cond.stop |-> $past(low_seen_r) && $past(scl_q_r) && !$past(sda_p_r);
  endproperty
  a_stop_needs_low: assert property (p_stop_needs_low) else $error("stop without scl low");

  property p_restart;
    sda_fall_hi && busy_r && low_seen_r |=> cond.restart && !cond.start && busy_r;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not flagged");

  property p_restart_resets;
    cond.restart |-> state_r == st_first && bit_cnt_r == 4'h0 && !addressed && !scl_oe;
  endproperty
  a_restart_resets: assert property (p_restart_resets) else $error("restart left state");

  sequence s_read_hi;
    capture && state_r == st_first && ten_bit_mode && hi_match && shift_r[0] && prior_match;
  endsequence
  sequence s_ack_done;
    ack_fall && !sda_fall_hi && !stop_ok;
  endsequence

  property p_hold;
    s_read_hi ##1 (hold_pend_r && !sda_fall_hi && !stop_ok) [*1] |-> addressed && read_mode;
  endproperty
  a_hold: assert property (p_hold) else $error("read turnaround not armed");

  property p_hold_stretch;
    (hold_pend_r && state_r == st_data) and s_ack_done |=> scl_oe && state_r == st_hold;
  endproperty
  a_hold_stretch: assert property (p_hold_stretch) else $error("scl not held");

  property p_prior;
    (capture && state_r == st_second && lo_match && !stop_ok |=> prior_match)
      and (cond.stop |-> !prior_match);
  endproperty
  a_prior: assert property (p_prior) else $error("prior match flag wrong");

  property p_start;
    sda_fall_hi && !(busy_r && low_seen_r) |=> cond.start && state_r == st_first;
  endproperty
  a_start: assert property (p_start) else $error("start not flagged");

endmodule : i2c_cond_detect

// >>> testbench/i2c_master_model.sv
// i2c bus master model driving scl and sda of the slave
module i2c_master_model (
  input wire logic link_clk,
  input wire logic scl_line,
  output logic scl_m,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  // released scl never came back high within the bound
  int stalls = 0;

  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic half();
    repeat (24) @(posedge link_clk);
  endtask : half

  // release scl, then wait while the slave stretches it
  task automatic rise();
    int n;
    n = 0;
    scl_m <= 1'b1;
    @(posedge link_clk);
    while (scl_line !== 1'b1 && n < 500)
    begin
      @(posedge link_clk);
      n++;
    end
    if (n >= 500)
      stalls++;
    half();
  endtask : rise

  task automatic low();
    scl_m <= 1'b0;
    half();
  endtask : low

  task automatic start();
    sda_m <= 1'b0;
    half();
    scl_m <= 1'b0;
    half();
  endtask : start

  // keeps the bus instead of stopping
  task automatic restart();
    sda_m <= 1'b1;
    half();
    rise();
    start();
  endtask : restart

  task automatic stop();
    sda_m <= 1'b0;
    half();
    rise();
    sda_m <= 1'b1;
    half();
  endtask : stop

  // sda low then high with scl never low
  task automatic glitch();
    sda_m <= 1'b0;
    half();
    sda_m <= 1'b1;
    half();
  endtask : glitch

  // msb first, then a released ack clock
  task automatic put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--)
    begin
      sda_m <= (i == 0) ? 1'b1 : b[i-1];
      half();
      rise();
      scl_m <= 1'b0;
      half();
    end
  endtask : put_byte
endmodule : i2c_master_model

// >>> testbench/i2c_slave_bus_condition_detect_tb_top.sv
// testbench for the i2c slave bus condition detector
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module i2c_slave_bus_condition_detect_tb_top import i2c_cond_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ten_bit_mode = 1'b0;
  logic tx_ready = 1'b0;
  logic [9:0] own_addr = 10'h02A;
  logic scl_m, sda_m, scl_o, scl_oe, addressed, read_mode, prior_match;
  cond_evt_t cond;
  rx_byte_t rx_byte;
  wire scl_line = scl_m & (scl_oe ? scl_o : 1'b1);
  int failures = 0;
  int comparisons = 0;
  int n_st = 0;
  int n_rs = 0;
  int n_sp = 0;
  int n_rx = 0;

  always #20 ref_clk = ~ref_clk;
  always #6 link_clk = ~link_clk;

  always @(posedge ref_clk)
  begin
    n_st <= n_st + int'(cond.start);
    n_rs <= n_rs + int'(cond.restart);
    n_sp <= n_sp + int'(cond.stop);
    n_rx <= n_rx + int'(rx_byte.valid);
  end

  i2c_master_model i2c_master_model_inst (.link_clk(link_clk), .scl_line(scl_line),
    .scl_m(scl_m), .sda_m(sda_m));

  i2c_cond_detect i2c_cond_detect_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl_clk(scl_line), .scl_i(scl_line), .sda_i(sda_m), .own_addr(own_addr),
    .ten_bit_mode(ten_bit_mode), .tx_ready(tx_ready), .scl_o(scl_o), .scl_oe(scl_oe),
    .cond(cond), .rx_byte(rx_byte), .addressed(addressed), .read_mode(read_mode),
    .prior_match(prior_match));

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic sc_seven_bit();
    int s, p, b;
    s = n_st;
    p = n_sp;
    b = n_rx;
    i2c_master_model_inst.start();
    `CHK("start", s + 1, n_st)
    i2c_master_model_inst.put_byte(8'h54);
    `CHK("addressed", 1'b1, addressed)
    `CHK("address byte", 8'h54, rx_byte.data)
    `CHK("byte count", b + 1, n_rx)
    `CHK("write direction", 1'b0, read_mode)
    i2c_master_model_inst.stop();
    `CHK("stop", p + 1, n_sp)
    `CHK("addressed after stop", 1'b0, addressed)
  endtask : sc_seven_bit

  task automatic sc_false_stop();
    int s, p, r;
    s = n_st;
    p = n_sp;
    r = n_rs;
    i2c_master_model_inst.glitch();
    `CHK("glitch start", s + 1, n_st)
    `CHK("glitch stop", p, n_sp)
    `CHK("glitch restart", r, n_rs)
  endtask : sc_false_stop

  task automatic sc_ten_bit();
    int r, p;
    @(posedge ref_clk);
    ten_bit_mode <= 1'b1;
    own_addr <= 10'h2A5;
    r = n_rs;
    p = n_sp;
    i2c_master_model_inst.start();
    i2c_master_model_inst.put_byte(8'hF4);
    i2c_master_model_inst.put_byte(8'hA5);
    `CHK("low byte", 8'hA5, rx_byte.data)
    `CHK("prior match", 1'b1, prior_match)
    i2c_master_model_inst.restart();
    `CHK("restart", r + 1, n_rs)
    `CHK("addressed after restart", 1'b0, addressed)
    `CHK("prior kept", 1'b1, prior_match)
    i2c_master_model_inst.put_byte(8'hF5);
    // master lets scl go, so only the slave can keep it low
    fork
      i2c_master_model_inst.rise();
    join_none
    repeat (20) @(posedge ref_clk);
    `CHK("read addressed", 1'b1, addressed)
    `CHK("read mode", 1'b1, read_mode)
    `CHK("stretch", 1'b1, scl_oe)
    `CHK("scl drive level", 1'b0, scl_o)
    `CHK("scl held", 1'b0, scl_line)
    tx_ready <= 1'b1;
    @(posedge ref_clk);
    tx_ready <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("stretch released", 1'b0, scl_oe)
    wait fork;
    `CHK("scl freed", 1'b1, scl_line)
    i2c_master_model_inst.low();
    i2c_master_model_inst.stop();
    `CHK("final stop", p + 1, n_sp)
    `CHK("prior cleared", 1'b0, prior_match)
    `CHK("addressed cleared", 1'b0, addressed)
  endtask : sc_ten_bit

  task automatic sc_prior_clear();
    int r;
    r = n_rs;
    i2c_master_model_inst.start();
    i2c_master_model_inst.put_byte(8'hF4);
    i2c_master_model_inst.put_byte(8'hA5);
    `CHK("prior set", 1'b1, prior_match)
    i2c_master_model_inst.restart();
    i2c_master_model_inst.put_byte(8'hF4);
    `CHK("prior cleared by write high", 1'b0, prior_match)
    i2c_master_model_inst.put_byte(8'hA5);
    `CHK("prior set again", 1'b1, prior_match)
    i2c_master_model_inst.restart();
    i2c_master_model_inst.put_byte(8'hF1);
    `CHK("prior cleared by miss", 1'b0, prior_match)
    `CHK("miss addressed", 1'b0, addressed)
    i2c_master_model_inst.restart();
    i2c_master_model_inst.put_byte(8'hF5);
    `CHK("read without prior", 1'b0, addressed)
    `CHK("no stretch", 1'b0, scl_oe)
    `CHK("restarts", r + 3, n_rs)
    i2c_master_model_inst.stop();
  endtask : sc_prior_clear

  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sc_seven_bit();
    sc_false_stop();
    sc_ten_bit();
    sc_prior_clear();
    `CHK("scl stall", 0, i2c_master_model_inst.stalls)
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
endmodule : i2c_slave_bus_condition_detect_tb_top
